// ==== rtl/fcrs_consts.vh ====
// Notes on behaviour
// - Host holds reset low at least the minimum reset pulse time.
// - Host waits the wake-up time after reset release before reading.
// - Host waits the reset-to-write time after reset release before writing.
// - Flash reset follows the same reset that resets the processor.
// - Commands are bus writes: a setup write, often followed by a confirm write.
// - Page config: setup 0060h, confirm 0004h, register value on the address bus.
// - Status-pin config: setup 00B8h, confirm carries the value on data.
// - Single writes 00FFh, 0070h, 0090h, 0098h select the read modes.
`ifndef FCRS_CONSTS_VH
`define FCRS_CONSTS_VH

`define FCRS_CLK_MHZ 25
`define FCRS_T_RESET_PULSE_NS 25000
`define FCRS_T_WAKE_NS 210
`define FCRS_T_RESET_WRITE_NS 210
`define FCRS_CYC_RESET_PULSE ((`FCRS_T_RESET_PULSE_NS * `FCRS_CLK_MHZ + 999) / 1000)
`define FCRS_CYC_WAKE ((`FCRS_T_WAKE_NS * `FCRS_CLK_MHZ + 999) / 1000)
`define FCRS_CYC_RESET_WRITE ((`FCRS_T_RESET_WRITE_NS * `FCRS_CLK_MHZ + 999) / 1000)
`define FCRS_CYC_WE_LOW 3
`define FCRS_CYC_READ 3
`define FCRS_CYC_GAP 2

`define FCRS_OP_READ_ARRAY 4'h0
`define FCRS_OP_READ_STATUS 4'h1
`define FCRS_OP_READ_ID 4'h2
`define FCRS_OP_READ_QUERY 4'h3
`define FCRS_OP_CLEAR_STATUS 4'h4
`define FCRS_OP_PAGE_CONFIG 4'h5
`define FCRS_OP_STS_CONFIG 4'h6
`define FCRS_OP_PROGRAM 4'h7
`define FCRS_OP_BUF_PROGRAM 4'h8
`define FCRS_OP_ERASE 4'h9
`define FCRS_OP_SUSPEND 4'ha
`define FCRS_OP_RESUME 4'hb
`define FCRS_OP_LOCK 4'hc
`define FCRS_OP_UNLOCK 4'hd
`define FCRS_OP_OTP 4'he
`define FCRS_OP_READ 4'hf

`define FCRS_CMD_READ_ARRAY 16'h00ff
`define FCRS_CMD_READ_STATUS 16'h0070
`define FCRS_CMD_READ_ID 16'h0090
`define FCRS_CMD_READ_QUERY 16'h0098
`define FCRS_CMD_CLEAR_STATUS 16'h0050
`define FCRS_CMD_PAGE_SETUP 16'h0060
`define FCRS_CMD_PAGE_CONFIRM 16'h0004
`define FCRS_CMD_STS_SETUP 16'h00b8
`define FCRS_CMD_PROGRAM 16'h0040
`define FCRS_CMD_BUF_PROGRAM 16'h00e8
`define FCRS_CMD_CONFIRM 16'h00d0
`define FCRS_CMD_ERASE 16'h0020
`define FCRS_CMD_SUSPEND 16'h00b0
`define FCRS_CMD_LOCK_SETUP 16'h0060
`define FCRS_CMD_LOCK_CONFIRM 16'h0001
`define FCRS_CMD_OTP 16'h00c0
`define FCRS_PAGE_LEN_BIT 13
`define FCRS_STATUS_DEFAULT 16'h0080

`endif

// ==== rtl/fcrs_sync3.v ====
`timescale 1ns/1ps
`default_nettype none
module fcrs_sync3 (
  // Clock, reset and enable
  input wire clock_in,
  input wire rst_n_in,
  input wire ce_in,
  // Async level
  input wire async_in,
  output reg level_out
);
  reg s1_ff;
  reg s2_ff;
  reg s3_ff;
  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      level_out <= 1'b0;
    end else if (ce_in) begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        level_out <= s3_ff;
      end
    end
  end
endmodule
`default_nettype wire

// ==== rtl/fcrs_host.v ====
`timescale 1ns/1ps
`default_nettype none
`include "fcrs_consts.vh"
module fcrs_host (
  // Clock, reset, enable
  input wire clock_in,
  input wire rst_n_in,
  input wire ce_in,
  // Request port
  input wire req_valid_in,
  input wire [3:0] req_op_in,
  input wire [22:0] req_addr_in,
  input wire [15:0] req_data_in,
  input wire prog_supply_high_in,
  output wire req_ready_out,
  output reg done_out,
  output reg refused_out,
  output reg [15:0] rd_data_out,
  output reg flash_ready_out,
  // Flash pins
  output reg chip_select_zero_n_out,
  output reg write_enable_n_out,
  output reg output_enable_n_out,
  output reg reset_powerdown_n_out,
  output reg [22:0] addr_out,
  output reg [15:0] dq_out,
  output reg dq_oe_n_out,
  input wire [15:0] dq_in,
  input wire ready_status_pin_in
);
  localparam ST_RESET = 3'd0;
  localparam ST_WAKE = 3'd1;
  localparam ST_IDLE = 3'd2;
  localparam ST_WLOW = 3'd3;
  localparam ST_WGAP = 3'd4;
  localparam ST_RLOW = 3'd5;
  localparam ST_DONE = 3'd6;
  localparam integer PULSE_INT = `FCRS_CYC_RESET_PULSE - 1;
  localparam integer WAKE_INT = ((`FCRS_CYC_WAKE > `FCRS_CYC_RESET_WRITE) ?
    `FCRS_CYC_WAKE : `FCRS_CYC_RESET_WRITE) - 1;
  localparam integer WE_INT = `FCRS_CYC_WE_LOW - 1;
  localparam integer GAP_INT = `FCRS_CYC_GAP - 1;
  localparam integer READ_INT = `FCRS_CYC_READ + 1;
  // Last count of each timed phase, cut to the counter width
  localparam [15:0] PULSE_LAST = PULSE_INT[15:0];
  localparam [15:0] WAKE_LAST = WAKE_INT[15:0];
  localparam [15:0] WE_LAST = WE_INT[15:0];
  localparam [15:0] GAP_LAST = GAP_INT[15:0];
  localparam [15:0] READ_LAST = READ_INT[15:0];

  reg [2:0] state_ff;
  reg [15:0] cnt_ff;
  reg second_ff;
  reg two_ff;
  reg [15:0] cyc2_data_ff;
  reg [22:0] cyc2_addr_ff;
  reg [15:0] dq_s1_ff;
  reg [15:0] dq_s2_ff;
  wire sts_level;
  reg [15:0] d1;
  reg [22:0] a2;
  reg [15:0] d2;
  reg two;
  reg needs_supply;

  fcrs_sync3 u_sts (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .async_in(ready_status_pin_in),
    .level_out(sts_level)
  );

  assign req_ready_out = (state_ff == ST_IDLE);

  // Decode operation into one or two bus writes
  always @* begin
    d1 = `FCRS_CMD_READ_ARRAY;
    a2 = req_addr_in;
    d2 = `FCRS_CMD_CONFIRM;
    two = 1'b0;
    needs_supply = 1'b0;
    case (req_op_in)
      `FCRS_OP_READ_ARRAY: d1 = `FCRS_CMD_READ_ARRAY;
      `FCRS_OP_READ_STATUS: d1 = `FCRS_CMD_READ_STATUS;
      `FCRS_OP_READ_ID: d1 = `FCRS_CMD_READ_ID;
      `FCRS_OP_READ_QUERY: d1 = `FCRS_CMD_READ_QUERY;
      `FCRS_OP_CLEAR_STATUS: d1 = `FCRS_CMD_CLEAR_STATUS;
      `FCRS_OP_PAGE_CONFIG: begin
        // Value travels on the address bus in both cycles, bit 13 only
        d1 = `FCRS_CMD_PAGE_SETUP;
        d2 = `FCRS_CMD_PAGE_CONFIRM;
        two = 1'b1;
        a2 = 23'h0;
        a2[`FCRS_PAGE_LEN_BIT] = req_addr_in[`FCRS_PAGE_LEN_BIT];
      end
      `FCRS_OP_STS_CONFIG: begin
        d1 = `FCRS_CMD_STS_SETUP;
        d2 = req_data_in;
        two = 1'b1;
      end
      `FCRS_OP_PROGRAM: begin
        d1 = `FCRS_CMD_PROGRAM;
        d2 = req_data_in;
        two = 1'b1;
        needs_supply = 1'b1;
      end
      `FCRS_OP_BUF_PROGRAM: begin
        d1 = `FCRS_CMD_BUF_PROGRAM;
        two = 1'b1;
        needs_supply = 1'b1;
      end
      `FCRS_OP_ERASE: begin
        d1 = `FCRS_CMD_ERASE;
        two = 1'b1;
        needs_supply = 1'b1;
      end
      `FCRS_OP_SUSPEND: d1 = `FCRS_CMD_SUSPEND;
      `FCRS_OP_RESUME: d1 = `FCRS_CMD_CONFIRM;
      `FCRS_OP_LOCK: begin
        d1 = `FCRS_CMD_LOCK_SETUP;
        d2 = `FCRS_CMD_LOCK_CONFIRM;
        two = 1'b1;
        needs_supply = 1'b1;
      end
      `FCRS_OP_UNLOCK: begin
        d1 = `FCRS_CMD_LOCK_SETUP;
        two = 1'b1;
        needs_supply = 1'b1;
      end
      `FCRS_OP_OTP: begin
        d1 = `FCRS_CMD_OTP;
        d2 = req_data_in;
        two = 1'b1;
        needs_supply = 1'b1;
      end
      default: d1 = `FCRS_CMD_READ_ARRAY;
    endcase
  end

  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      // Flash reset follows the system reset
      state_ff <= ST_RESET;
      cnt_ff <= 16'h0000;
      second_ff <= 1'b0;
      two_ff <= 1'b0;
      cyc2_data_ff <= 16'h0000;
      cyc2_addr_ff <= 23'h000000;
      dq_s1_ff <= 16'h0000;
      dq_s2_ff <= 16'h0000;
      done_out <= 1'b0;
      refused_out <= 1'b0;
      rd_data_out <= 16'h0000;
      flash_ready_out <= 1'b0;
      chip_select_zero_n_out <= 1'b1;
      write_enable_n_out <= 1'b1;
      output_enable_n_out <= 1'b1;
      reset_powerdown_n_out <= 1'b0;
      addr_out <= 23'h000000;
      dq_out <= 16'h0000;
      dq_oe_n_out <= 1'b1;
    end else if (ce_in) begin
      dq_s1_ff <= dq_in;
      dq_s2_ff <= dq_s1_ff;
      done_out <= 1'b0;
      refused_out <= 1'b0;
      flash_ready_out <= sts_level && (state_ff != ST_RESET) && (state_ff != ST_WAKE);
      case (state_ff)
        ST_RESET: begin
          // Hold reset low for the minimum pulse
          reset_powerdown_n_out <= 1'b0;
          if (cnt_ff >= PULSE_LAST) begin
            cnt_ff <= 16'h0000;
            reset_powerdown_n_out <= 1'b1;
            state_ff <= ST_WAKE;
          end else begin
            cnt_ff <= cnt_ff + 16'h0001;
          end
        end
        ST_WAKE: begin
          // No read or write before wake and reset-to-write times
          if (cnt_ff >= WAKE_LAST) begin
            cnt_ff <= 16'h0000;
            state_ff <= ST_IDLE;
          end else begin
            cnt_ff <= cnt_ff + 16'h0001;
          end
        end
        ST_IDLE: begin
          chip_select_zero_n_out <= 1'b1;
          if (req_valid_in) begin
            if (needs_supply && !prog_supply_high_in && req_op_in != `FCRS_OP_READ) begin
              refused_out <= 1'b1;
            end else if (req_op_in == `FCRS_OP_READ) begin
              addr_out <= req_addr_in;
              chip_select_zero_n_out <= 1'b0;
              output_enable_n_out <= 1'b0;
              dq_oe_n_out <= 1'b1;
              cnt_ff <= 16'h0000;
              state_ff <= ST_RLOW;
            end else begin
              // First bus write carries the setup code
              addr_out <= (req_op_in == `FCRS_OP_PAGE_CONFIG) ? a2 : req_addr_in;
              dq_out <= d1;
              dq_oe_n_out <= 1'b0;
              chip_select_zero_n_out <= 1'b0;
              write_enable_n_out <= 1'b0;
              two_ff <= two;
              second_ff <= 1'b0;
              cyc2_addr_ff <= a2;
              cyc2_data_ff <= d2;
              cnt_ff <= 16'h0000;
              state_ff <= ST_WLOW;
            end
          end
        end
        ST_WLOW: begin
          if (cnt_ff >= WE_LAST) begin
            write_enable_n_out <= 1'b1;
            cnt_ff <= 16'h0000;
            state_ff <= ST_WGAP;
          end else begin
            cnt_ff <= cnt_ff + 16'h0001;
          end
        end
        ST_WGAP: begin
          if (cnt_ff >= GAP_LAST) begin
            cnt_ff <= 16'h0000;
            if (two_ff && !second_ff) begin
              // Confirm write follows the setup
              second_ff <= 1'b1;
              addr_out <= cyc2_addr_ff;
              dq_out <= cyc2_data_ff;
              write_enable_n_out <= 1'b0;
              state_ff <= ST_WLOW;
            end else begin
              chip_select_zero_n_out <= 1'b1;
              dq_oe_n_out <= 1'b1;
              state_ff <= ST_DONE;
            end
          end else begin
            cnt_ff <= cnt_ff + 16'h0001;
          end
        end
        ST_RLOW: begin
          if (cnt_ff >= READ_LAST) begin
            rd_data_out <= dq_s2_ff;
            output_enable_n_out <= 1'b1;
            chip_select_zero_n_out <= 1'b1;
            state_ff <= ST_DONE;
          end else begin
            cnt_ff <= cnt_ff + 16'h0001;
          end
        end
        ST_DONE: begin
          done_out <= 1'b1;
          state_ff <= ST_IDLE;
        end
        default: state_ff <= ST_RESET;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== rtl/fcrs_dummy_unused.v ====
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== bench/fcrs_flash_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module fcrs_flash_model #(
  parameter logic [15:0] ID_VAL = 16'h5a5a, // Arbitrary value
  parameter logic [15:0] QUERY_VAL = 16'h0051,
  parameter int BUSY_NS = 2000
) (
  // Controls
  input wire logic cs_n_in,
  input wire logic we_n_in,
  input wire logic oe_n_in,
  input wire logic rp_n_in,
  input wire logic supply_high_in,
  // Bus
  input wire logic [22:0] addr_in,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic sts_out
);
  logic [15:0] mem [0:15];
  logic [15:0] st = 16'h0080;
  logic [15:0] setup = 16'h0;
  logic [15:0] last = 16'h0;
  logic [15:0] rv;
  logic [22:0] sa;
  logic [1:0] mode = 2'h0;
  logic busy = 1'b0;
  logic ok, modify;
  initial for (int i = 0; i < 16; i++) mem[i] = 16'hffff;
  always @(negedge rp_n_in) begin
    mode = 2'h0;
    st = 16'h0080;
    setup = 16'h0;
    busy = 1'b0;
  end
  always @(posedge busy) begin
    #(BUSY_NS);
    busy = 1'b0;
  end
  always @(posedge we_n_in) if (!cs_n_in && rp_n_in) begin
    if (setup != 16'h0) begin
      ok = setup inside {16'h0040, 16'h0010, 16'h00c0, 16'h00b8} || setup == 16'h0060 &&
        (dq_in inside {16'h0001, 16'h00d0} || dq_in == 16'h0004 && addr_in == sa) ||
        setup inside {16'h0020, 16'h00e8} && dq_in == 16'h00d0;
      modify = !(setup == 16'h00b8 || setup == 16'h0060 && dq_in == 16'h0004);
      if (!ok) st[5:4] = 2'b11;
      else if (modify && !supply_high_in) st[3] = 1'b1;
      else if (modify) begin
        busy = 1'b1;
        if (setup inside {16'h0040, 16'h0010}) mem[addr_in[3:0]] &= dq_in;
        if (setup == 16'h0020) for (int i = 0; i < 16; i++) mem[i] = 16'hffff;
      end
      mode = modify ? 2'h1 : 2'h0;
      setup = 16'h0;
    end else case (dq_in)
      16'h00ff: mode = 2'h0;
      16'h0070, 16'h00b0, 16'h00d0: mode = 2'h1;
      16'h0090: mode = 2'h2;
      16'h0098: mode = 2'h3;
      16'h0050: begin
        st = 16'h0080;
        mode = 2'h1;
      end
      default: begin
        setup = dq_in;
        sa = addr_in;
      end
    endcase
  end
  always_comb begin
    case (mode)
      2'h0: rv = mem[addr_in[3:0]];
      2'h1: rv = {st[15:8], !busy, st[6:0]};
      2'h2: rv = ID_VAL;
      default: rv = QUERY_VAL;
    endcase
  end
  assign dq_out = !cs_n_in && !oe_n_in && rp_n_in ? rv : ~last;
  always @(rv or cs_n_in or oe_n_in) if (!cs_n_in && !oe_n_in && rp_n_in) last = rv;
  assign sts_out = rp_n_in && !busy;
endmodule
`default_nettype wire

// ==== bench/fcrs_host_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module fcrs_host_checker (
  // Watched ports
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic req_valid_in,
  input wire logic [3:0] req_op_in,
  input wire logic prog_supply_high_in,
  input wire logic req_ready_out,
  input wire logic chip_select_zero_n_out,
  input wire logic write_enable_n_out,
  input wire logic output_enable_n_out,
  input wire logic reset_powerdown_n_out,
  input wire logic [15:0] dq_out,
  input wire logic dq_oe_n_out,
  input wire logic refused_out
);
  logic [9:0] low = 10'h0;
  logic [3:0] up = 4'h0;
  wire logic take = req_valid_in && req_ready_out;
  wire logic modop = req_op_in inside {4'h7, 4'h8, 4'h9, 4'hc, 4'hd, 4'he};
  always @(posedge clock_in) begin
    low <= (!rst_n_in || reset_powerdown_n_out) ? 10'h0 : low + {9'h0, low != 10'h3ff};
    up <= (!rst_n_in || !reset_powerdown_n_out) ? 4'h0 : up + {3'h0, up != 4'hf};
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  a_reset_pulse_len: assert property ($rose(reset_powerdown_n_out) |-> low >= 10'd625)
    else $error("flash reset pulse short");
  a_write_after_wake: assert property ($fell(write_enable_n_out) |-> up >= 4'd6)
    else $error("write too soon");
  a_read_after_wake: assert property ($fell(output_enable_n_out) |-> up >= 4'd6)
    else $error("read too soon");
  a_reset_quiets_bus: assert property (!reset_powerdown_n_out |->
    chip_select_zero_n_out && write_enable_n_out && !req_ready_out) else $error("bus busy");
  a_write_owns_bus: assert property (!write_enable_n_out |->
    !chip_select_zero_n_out && !dq_oe_n_out && output_enable_n_out) else $error("bad write");
  a_strobe_three: assert property ($fell(write_enable_n_out) |->
    (!write_enable_n_out) [*3] ##1 write_enable_n_out) else $error("strobe width");
  a_data_held: assert property (!write_enable_n_out && !$past(write_enable_n_out) |->
    $stable(dq_out)) else $error("data moved");
  a_lockout_refused: assert property (take && modop && !prog_supply_high_in |->
    ##[1:2] refused_out) else $error("no refusal");
  a_two_writes: assert property (take && modop && prog_supply_high_in |->
    ##[1:4] $fell(write_enable_n_out) ##[3:8] $fell(write_enable_n_out)) else $error("one write");
  cover property (refused_out);
  cover property ($fell(output_enable_n_out));
  cover property (take && modop && prog_supply_high_in);
endmodule
bind fcrs_host fcrs_host_checker chk_u (.clock_in, .rst_n_in, .req_valid_in, .req_op_in,
  .prog_supply_high_in, .req_ready_out, .chip_select_zero_n_out, .write_enable_n_out,
  .output_enable_n_out, .reset_powerdown_n_out, .dq_out, .dq_oe_n_out, .refused_out);
`default_nettype wire

// ==== bench/fcrs_host_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fcrs_consts.vh"
module fcrs_host_tb;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic req_valid_in = 1'b0;
  logic prog_supply_high_in = 1'b1;
  logic ce_in = 1'b1;
  logic [3:0] req_op_in = 4'h0;
  logic [22:0] req_addr_in = 23'h0;
  logic [15:0] req_data_in = 16'h0;
  logic req_ready_out, done_out, refused_out, flash_ready_out, chip_select_zero_n_out, sts;
  logic write_enable_n_out, output_enable_n_out, reset_powerdown_n_out, dq_oe_n_out, refd;
  logic [22:0] addr_out;
  logic [15:0] rd_data_out, dq_out, fl_dq, em [0:15];
  logic [3:0] mods [6] = '{4'h7, 4'h8, 4'h9, 4'hc, 4'hd, 4'he};
  logic [31:0] rng = 32'd71884;
  logic [3:0] a;
  int bad_count = 0;
  int total_checks = 0;
  wire [15:0] dq_bus = dq_oe_n_out ? fl_dq : dq_out;
  always #20 clock_in = ~clock_in;
  fcrs_host dut_u (.clock_in, .rst_n_in, .ce_in, .req_valid_in, .req_op_in, .req_addr_in,
    .req_data_in, .prog_supply_high_in, .req_ready_out, .done_out, .refused_out, .rd_data_out,
    .flash_ready_out, .chip_select_zero_n_out, .write_enable_n_out, .output_enable_n_out,
    .reset_powerdown_n_out, .addr_out, .dq_out, .dq_oe_n_out, .dq_in(dq_bus),
    .ready_status_pin_in(sts));
  fcrs_flash_model fl_u (.cs_n_in(chip_select_zero_n_out), .we_n_in(write_enable_n_out),
    .oe_n_in(output_enable_n_out), .rp_n_in(reset_powerdown_n_out),
    .supply_high_in(prog_supply_high_in), .addr_in(addr_out), .dq_in(dq_bus),
    .dq_out(fl_dq), .sts_out(sts));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [15:0] prog_val(input logic [15:0] o, input logic [15:0] n);
    return o & n;
  endfunction
  task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic req(input logic [3:0] op, input logic [22:0] ad, input logic [15:0] d);
    int n;
    n = 0;
    req_op_in = op;
    req_addr_in = ad;
    req_data_in = d;
    req_valid_in = 1'b1;
    while (req_ready_out !== 1'b1 && n < 900) begin
      @(negedge clock_in);
      n++;
    end
    @(negedge clock_in);
    req_valid_in = 1'b0;
    while (done_out !== 1'b1 && refused_out !== 1'b1 && n < 960) begin
      @(negedge clock_in);
      n++;
    end
    refd = refused_out;
    chk("answer", 16'h0, {15'h0, n >= 960});
    @(negedge clock_in);
  endtask
  task automatic rd(input logic [22:0] ad, input logic [15:0] e, input string w);
    req(`FCRS_OP_READ, ad, 16'h0);
    chk(w, e, rd_data_out);
  endtask
  task automatic wait_fr;
    int n;
    n = 0;
    repeat (6) @(negedge clock_in);
    while (flash_ready_out !== 1'b1 && n < 300) begin
      @(negedge clock_in);
      n++;
    end
    chk("flash ready", 16'h1, {15'h0, flash_ready_out});
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #800000;
    bad_count++;
    final_report;
  end
  initial begin
    for (int i = 0; i < 16; i++) em[i] = 16'hffff;
    repeat (6) @(negedge clock_in);
    rst_n_in = 1'b1;
    repeat (20) @(negedge clock_in);
    chk("ready pin", 16'h0, {15'h0, flash_ready_out});
    rd(23'h0, 16'hffff, "array after reset");
    ce_in = 1'b0;
    req_op_in = `FCRS_OP_READ;
    req_valid_in = 1'b1;
    repeat (4) @(negedge clock_in);
    chk("frozen select", 16'h1, {15'h0, chip_select_zero_n_out});
    req_valid_in = 1'b0;
    ce_in = 1'b1;
    @(negedge clock_in);
    req(`FCRS_OP_READ_STATUS, 23'h0, 16'h0);
    rd(23'h0, `FCRS_STATUS_DEFAULT, "status");
    req(`FCRS_OP_READ_ID, 23'h0, 16'h0);
    rd(23'h0, 16'h5a5a, "identifier");
    req(`FCRS_OP_READ_QUERY, 23'h10, 16'h0);
    rd(23'h10, 16'h0051, "query");
    for (int i = 0; i < 8; i++) begin
      rng = xs(rng);
      a = i == 0 ? 4'h0 : i == 1 ? 4'hf : rng[3:0];
      req(`FCRS_OP_PROGRAM, {19'h0, a}, rng[31:16]);
      em[a] = prog_val(em[a], rng[31:16]);
      wait_fr;
      req(`FCRS_OP_READ_ARRAY, 23'h0, 16'h0);
      rd({19'h0, a}, em[a], "programmed word");
    end
    prog_supply_high_in = 1'b0;
    foreach (mods[i]) begin
      req(mods[i], 23'h3, 16'h0);
      chk("refusal", 16'h1, {15'h0, refd});
    end
    prog_supply_high_in = 1'b1;
    req(`FCRS_OP_READ_ARRAY, 23'h0, 16'h0);
    rd(23'h3, em[3], "word after lockout");
    for (int op = 0; op < 15; op++) begin
      req(op[3:0], 23'h2000, 16'h0001);
      wait_fr;
    end
    req(`FCRS_OP_READ_STATUS, 23'h0, 16'h0);
    rd(23'h0, `FCRS_STATUS_DEFAULT, "status after commands");
    req(`FCRS_OP_READ_ARRAY, 23'h0, 16'h0);
    rd(23'h0, 16'hffff, "erased word");
    req(`FCRS_OP_ERASE, 23'h0, 16'h0);
    rst_n_in = 1'b0;
    repeat (2) @(negedge clock_in);
    rst_n_in = 1'b1;
    @(negedge clock_in);
    chk("ready in reset", 16'h0, {15'h0, flash_ready_out});
    req(`FCRS_OP_READ_STATUS, 23'h0, 16'h0);
    rd(23'h0, `FCRS_STATUS_DEFAULT, "status after abort");
    final_report;
  end
endmodule
`default_nettype wire
